// ==== include/ppc_pkg.sv ====
// Package of register indices, widths, reset values and bus constants for the port pad block.
package ppc_pkg;

    // ------------------------------------------------------------------
    // Bus geometry.
    // ------------------------------------------------------------------
    localparam int          PPC_ADDR_W     = 12;     // APB byte address width.
    localparam int          PPC_DATA_W     = 32;     // APB data width.
    localparam int          PPC_IDX_W      = 10;     // Word index width, paddr[11:2].
    localparam int          PPC_IDX_LSB    = 2;      // Byte address is four times the index.
    localparam logic [1:0]  PPC_ALIGN_OK   = 2'h0;   // Low address bits of an aligned word.

    // ------------------------------------------------------------------
    // Port widths.
    // ------------------------------------------------------------------
    localparam int          PPC_PM_W       = 6;      // Implemented port M pins.
    localparam int          PPC_PP_W       = 8;      // Implemented port P pins.
    localparam int          PPC_REG_W      = 8;      // Width of every port P register; port M registers are 6 bits.

    // ------------------------------------------------------------------
    // Register indices (byte address = index * 4).
    // ------------------------------------------------------------------
    localparam logic [9:0]  PPC_IDX_PM_DATA      = 10'h010;
    localparam logic [9:0]  PPC_IDX_PM_DIRECTION = 10'h012;
    localparam logic [9:0]  PPC_IDX_PM_PULL_EN   = 10'h014;
    localparam logic [9:0]  PPC_IDX_PM_PULL_POL  = 10'h015;
    localparam logic [9:0]  PPC_IDX_PM_OPEN_DR   = 10'h016;
    localparam logic [9:0]  PPC_IDX_PP_DATA      = 10'h018;
    localparam logic [9:0]  PPC_IDX_PP_PIN_LEVEL = 10'h019;
    localparam logic [9:0]  PPC_IDX_PP_DIRECTION = 10'h01a;
    localparam logic [9:0]  PPC_IDX_PP_DRIVE     = 10'h01b;
    localparam logic [9:0]  PPC_IDX_PP_PULL_EN   = 10'h01c;
    localparam logic [9:0]  PPC_IDX_PP_PULL_POL  = 10'h01d;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [5:0]  PPC_RST_PM_PULL_EN   = 6'h3f;  // Pull-up on every port M pin.
    localparam logic [5:0]  PPC_RST_PM_ZERO      = 6'h00;
    localparam logic [7:0]  PPC_RST_PP_PULL_EN   = 8'h00;  // No port P pull device.
    localparam logic [7:0]  PPC_RST_PP_ZERO      = 8'h00;
    localparam logic [31:0] PPC_RST_RDATA        = 32'h0000_0000;

endpackage

// ==== rtl/ppc_pad_ctrl.sv ====
// Per-pin pad control: drive enable, open-drain, pull selection and reduced drive.
`timescale 1ns/100ps
module ppc_pad_ctrl #(
    parameter int WIDTH   = 8,
    parameter bit OD_PULL = 1'b0
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] out_data,
    input  wire logic [WIDTH-1:0] dir,
    input  wire logic [WIDTH-1:0] open_drain,
    input  wire logic [WIDTH-1:0] pull_en,
    input  wire logic [WIDTH-1:0] pull_pol,
    input  wire logic [WIDTH-1:0] reduced,
    output logic      [WIDTH-1:0] pad_out,
    output logic      [WIDTH-1:0] pad_oe,
    output logic      [WIDTH-1:0] pull_up,
    output logic      [WIDTH-1:0] pull_dn,
    output logic      [WIDTH-1:0] low_drive
);

    // ------------------------------------------------------------------
    // Pad state.
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] out_q,  out_d;   // Level presented to the pad driver.
    logic [WIDTH-1:0] oe_q,   oe_d;    // Driver enable, high while driving.
    logic [WIDTH-1:0] up_q,   up_d;    // Pull-up active.
    logic [WIDTH-1:0] dn_q,   dn_d;    // Pull-down active.
    logic [WIDTH-1:0] low_q,  low_d;   // Reduced drive strength active.
    logic [WIDTH-1:0] od_mask;         // Open-drain bits that are allowed to pull.

    // Next values from the configuration.
    always_comb begin
        // An open-drain output drives only a low level and floats for a one.
        out_d   = out_data & ~open_drain;
        oe_d    = dir & (~open_drain | ~out_data);
        // Only port M lets a wired-or output keep its pull-up.
        od_mask = OD_PULL ? (dir & open_drain) : '0;
        // Pull-up: on inputs, and on wired-or outputs where allowed.
        up_d    = pull_en & ~pull_pol & (~dir | od_mask);
        // Pull-down: inputs only, never while the pin drives.
        dn_d    = pull_en & pull_pol & ~dir;
        // Reduced drive matters only while the pin is an output.
        low_d   = reduced & dir;
    end

    // Registers: every pad control leaves a flip-flop, so pads see no glitches.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            out_q <= '0;
            oe_q  <= '0;
            up_q  <= '0;
            dn_q  <= '0;
            low_q <= '0;
        end else begin
            out_q <= out_d;
            oe_q  <= oe_d;
            up_q  <= up_d;
            dn_q  <= dn_d;
            low_q <= low_d;
        end
    end

    assign pad_out   = out_q;
    assign pad_oe    = oe_q;
    assign pull_up   = up_q;
    assign pull_dn   = dn_q;
    assign low_drive = low_q;

endmodule

// ==== rtl/ppc_port_pad_config_regs.sv ====
// APB register block and pad logic for port M pad configuration and port P general-purpose pins.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module ppc_port_pad_config_regs
    import ppc_pkg::*;
(
    input  wire logic [0:0]  clock,
    input  wire logic        sys_rst,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Port M pads.
    input  wire logic [5:0]  portm_pin_in,
    output logic      [5:0]  portm_pin_out,
    output logic      [5:0]  portm_pin_oe,
    output logic      [5:0]  portm_pull_up,
    output logic      [5:0]  portm_pull_down,
    // Port P pads.
    input  wire logic [7:0]  portp_pin_in,
    output logic      [7:0]  portp_pin_out,
    output logic      [7:0]  portp_pin_oe,
    output logic      [7:0]  portp_pull_up,
    output logic      [7:0]  portp_pull_down,
    output logic      [7:0]  portp_low_drive
);

    // ------------------------------------------------------------------
    // Port M registers.
    // ------------------------------------------------------------------
    logic [5:0] portm_data_q,            portm_data_d;            // Port M output latch.
    logic [5:0] portm_direction_q,       portm_direction_d;       // Port M direction, 1 is output.
    logic [5:0] portm_pull_enable_q,     portm_pull_enable_d;     // Port M pull enables.
    logic [5:0] portm_pull_polarity_q,   portm_pull_polarity_d;   // Port M pull polarity.
    logic [5:0] portm_open_drain_mode_q, portm_open_drain_mode_d; // Port M wired-or select.

    // ------------------------------------------------------------------
    // Port P registers.
    // ------------------------------------------------------------------
    logic [7:0] portp_data_q,            portp_data_d;            // Port P output latch.
    logic [7:0] portp_direction_q,       portp_direction_d;       // Port P direction, 1 is output.
    logic [7:0] portp_drive_strength_q,  portp_drive_strength_d;  // Port P reduced drive.
    logic [7:0] portp_pull_enable_q,     portp_pull_enable_d;     // Port P pull enables.
    logic [7:0] portp_pull_polarity_q,   portp_pull_polarity_d;   // Port P pull polarity.

    // ------------------------------------------------------------------
    // Bus answer registers and decode.
    // ------------------------------------------------------------------
    logic [31:0] prdata_q,  prdata_d;    // Read data captured in the setup cycle.
    logic        pslverr_q, pslverr_d;   // Error flag captured in the setup cycle.
    logic [9:0]  word_idx;               // Word index from the byte address.
    logic        aligned;                // Address falls on a word boundary.
    logic        setup_phase;            // First cycle of a transfer.
    logic        write_commit;           // Write takes effect at this edge.
    logic [7:0]  wbyte;                  // Low byte of the write data.
    logic [31:0] rd_value;               // Decoded read value of the addressed word.
    logic        hit;                    // Address names a register.

    // ------------------------------------------------------------------
    // Synchronised pin levels.
    // ------------------------------------------------------------------
    logic [5:0] portm_pin_sync;          // Port M pins after two flip-flops.
    logic [7:0] portp_pin_sync;          // Port P pins after two flip-flops.

    // Pins arrive from outside the clock domain and are synchronised first.
    // The two stages are the reason a read can trail a pin change.
    ppc_sync2 #(
        .WIDTH    (PPC_PM_W)
    ) u_sync_portm (
        .clock    (clock[0]),
        .sys_rst  (sys_rst),
        .async_in (portm_pin_in),
        .sync_out (portm_pin_sync)
    );

    ppc_sync2 #(
        .WIDTH    (PPC_PP_W)
    ) u_sync_portp (
        .clock    (clock[0]),
        .sys_rst  (sys_rst),
        .async_in (portp_pin_in),
        .sync_out (portp_pin_sync)
    );

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------
    assign word_idx     = paddr[11:PPC_IDX_LSB];
    assign aligned      = (paddr[1:0] == PPC_ALIGN_OK);
    assign setup_phase  = psel & ~penable;
    // Only the low byte lane carries data; a write without it changes nothing.
    assign write_commit = psel & penable & pwrite & pstrb[0];
    assign wbyte        = pwdata[7:0];

    // Read mux: an if/else-if chain over the word index; unmapped words read zero.
    always_comb begin
        rd_value = PPC_RST_RDATA;
        hit      = 1'b1;
        if (!aligned) begin
            hit = 1'b0;
        end else if (word_idx == PPC_IDX_PM_DATA) begin
            // Port M data follows the same latch-or-pin choice as port P.
            rd_value[5:0] = (portm_data_q & portm_direction_q) | (portm_pin_sync & ~portm_direction_q);
        end else if (word_idx == PPC_IDX_PM_DIRECTION) begin
            rd_value[5:0] = portm_direction_q;
        end else if (word_idx == PPC_IDX_PM_PULL_EN) begin
            rd_value[5:0] = portm_pull_enable_q;
        end else if (word_idx == PPC_IDX_PM_PULL_POL) begin
            rd_value[5:0] = portm_pull_polarity_q;
        end else if (word_idx == PPC_IDX_PM_OPEN_DR) begin
            rd_value[5:0] = portm_open_drain_mode_q;
        end else if (word_idx == PPC_IDX_PP_DATA) begin
            // Outputs read the latch, inputs the synchronised pin.
            rd_value[7:0] = (portp_data_q & portp_direction_q) | (portp_pin_sync & ~portp_direction_q);
        end else if (word_idx == PPC_IDX_PP_PIN_LEVEL) begin
            // Always the pin, so a shorted output shows up here.
            rd_value[7:0] = portp_pin_sync;
        end else if (word_idx == PPC_IDX_PP_DIRECTION) begin
            rd_value[7:0] = portp_direction_q;
        end else if (word_idx == PPC_IDX_PP_DRIVE) begin
            rd_value[7:0] = portp_drive_strength_q;
        end else if (word_idx == PPC_IDX_PP_PULL_EN) begin
            rd_value[7:0] = portp_pull_enable_q;
        end else if (word_idx == PPC_IDX_PP_PULL_POL) begin
            rd_value[7:0] = portp_pull_polarity_q;
        end else begin
            hit = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Register write logic.
    // ------------------------------------------------------------------
    // Next values: hold unless a committed write names the register.
    always_comb begin
        portm_data_d            = portm_data_q;
        portm_direction_d       = portm_direction_q;
        portm_pull_enable_d     = portm_pull_enable_q;
        portm_pull_polarity_d   = portm_pull_polarity_q;
        portm_open_drain_mode_d = portm_open_drain_mode_q;
        portp_data_d            = portp_data_q;
        portp_direction_d       = portp_direction_q;
        portp_drive_strength_d  = portp_drive_strength_q;
        portp_pull_enable_d     = portp_pull_enable_q;
        portp_pull_polarity_d   = portp_pull_polarity_q;
        if (write_commit && aligned) begin
            if (word_idx == PPC_IDX_PM_DATA) begin
                portm_data_d = wbyte[5:0];
            end else if (word_idx == PPC_IDX_PM_DIRECTION) begin
                portm_direction_d = wbyte[5:0];
            end else if (word_idx == PPC_IDX_PM_PULL_EN) begin
                // Bits 7 and 6 have no storage, so writes to them vanish.
                portm_pull_enable_d = wbyte[5:0];
            end else if (word_idx == PPC_IDX_PM_PULL_POL) begin
                portm_pull_polarity_d = wbyte[5:0];
            end else if (word_idx == PPC_IDX_PM_OPEN_DR) begin
                portm_open_drain_mode_d = wbyte[5:0];
            end else if (word_idx == PPC_IDX_PP_DATA) begin
                // The latch takes writes even while the pin is an input.
                portp_data_d = wbyte;
            end else if (word_idx == PPC_IDX_PP_DIRECTION) begin
                portp_direction_d = wbyte;
            end else if (word_idx == PPC_IDX_PP_DRIVE) begin
                portp_drive_strength_d = wbyte;
            end else if (word_idx == PPC_IDX_PP_PULL_EN) begin
                portp_pull_enable_d = wbyte;
            end else if (word_idx == PPC_IDX_PP_PULL_POL) begin
                portp_pull_polarity_d = wbyte;
            end else begin
                // The pin level word and unmapped words keep nothing.
                portp_data_d = portp_data_q;
            end
        end
    end

    // Registers: reset leaves port M pulled up and port P free of pulls.
    always_ff @(posedge clock[0]) begin
        if (sys_rst) begin
            portm_data_q            <= PPC_RST_PM_ZERO;
            portm_direction_q       <= PPC_RST_PM_ZERO;
            portm_pull_enable_q     <= PPC_RST_PM_PULL_EN;
            portm_pull_polarity_q   <= PPC_RST_PM_ZERO;
            portm_open_drain_mode_q <= PPC_RST_PM_ZERO;
            portp_data_q            <= PPC_RST_PP_ZERO;
            portp_direction_q       <= PPC_RST_PP_ZERO;
            portp_drive_strength_q  <= PPC_RST_PP_ZERO;
            portp_pull_enable_q     <= PPC_RST_PP_PULL_EN;
            portp_pull_polarity_q   <= PPC_RST_PP_ZERO;
        end else begin
            portm_data_q            <= portm_data_d;
            portm_direction_q       <= portm_direction_d;
            portm_pull_enable_q     <= portm_pull_enable_d;
            portm_pull_polarity_q   <= portm_pull_polarity_d;
            portm_open_drain_mode_q <= portm_open_drain_mode_d;
            portp_data_q            <= portp_data_d;
            portp_direction_q       <= portp_direction_d;
            portp_drive_strength_q  <= portp_drive_strength_d;
            portp_pull_enable_q     <= portp_pull_enable_d;
            portp_pull_polarity_q   <= portp_pull_polarity_d;
        end
    end

    // ------------------------------------------------------------------
    // Bus answer.
    // ------------------------------------------------------------------
    // Next values: read data and error are taken in the setup cycle.
    // Capturing early keeps prdata a flip-flop yet still answers with no wait state.
    always_comb begin
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        if (setup_phase) begin
            prdata_d  = pwrite ? PPC_RST_RDATA : rd_value;
            pslverr_d = ~hit;
        end
    end

    // Registers for the answer.
    always_ff @(posedge clock[0]) begin
        if (sys_rst) begin
            prdata_q  <= PPC_RST_RDATA;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // The slave never stalls: every access phase completes at once.
    assign pready  = psel & penable;
    assign pslverr = pslverr_q & psel & penable;
    assign prdata  = prdata_q;

    // ------------------------------------------------------------------
    // Pad control.
    // ------------------------------------------------------------------
    // Port M keeps its pull-up on wired-or outputs and has no reduced drive here.
    ppc_pad_ctrl #(
        .WIDTH      (PPC_PM_W),
        .OD_PULL    (1'b1)
    ) u_pad_portm (
        .clock      (clock[0]),
        .sys_rst    (sys_rst),
        .out_data   (portm_data_q),
        .dir        (portm_direction_q),
        .open_drain (portm_open_drain_mode_q),
        .pull_en    (portm_pull_enable_q),
        .pull_pol   (portm_pull_polarity_q),
        .reduced    (PPC_RST_PM_ZERO),
        .pad_out    (portm_pin_out),
        .pad_oe     (portm_pin_oe),
        .pull_up    (portm_pull_up),
        .pull_dn    (portm_pull_down),
        .low_drive  ()
    );

    // Port P is push-pull only; its pulls act on inputs alone.
    ppc_pad_ctrl #(
        .WIDTH      (PPC_PP_W),
        .OD_PULL    (1'b0)
    ) u_pad_portp (
        .clock      (clock[0]),
        .sys_rst    (sys_rst),
        .out_data   (portp_data_q),
        .dir        (portp_direction_q),
        .open_drain (PPC_RST_PP_ZERO),
        .pull_en    (portp_pull_enable_q),
        .pull_pol   (portp_pull_polarity_q),
        .reduced    (portp_drive_strength_q),
        .pad_out    (portp_pin_out),
        .pad_oe     (portp_pin_oe),
        .pull_up    (portp_pull_up),
        .pull_dn    (portp_pull_down),
        .low_drive  (portp_low_drive)
    );

endmodule

// ==== rtl/ppc_sync2.sv ====
// Two-stage synchroniser for a bus of asynchronous pin levels.
`timescale 1ns/100ps
module ppc_sync2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Synchroniser stages.
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_q;  // First stage, read only by the second stage.
    logic [WIDTH-1:0] meta_d;  // Next value of the first stage.
    logic [WIDTH-1:0] sync_q;  // Second stage, safe for logic to read.
    logic [WIDTH-1:0] sync_d;  // Next value of the second stage.

    // Next values: the pins move one stage per edge.
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Registers: the reset value is a constant so no pin leaks in at reset.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

// ==== verif/ppc_pad_monitor.sv ====
// Checker of the pad outputs and bus answers of the port pad block.
`timescale 1ns/100ps
module ppc_pad_monitor (
    input wire logic [0:0]  clock,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic [5:0]  portm_pin_oe,
    input wire logic [5:0]  portm_pull_up,
    input wire logic [5:0]  portm_pull_down,
    input wire logic [7:0]  portp_pin_in,
    input wire logic [7:0]  portp_pin_oe,
    input wire logic [7:0]  portp_pull_up,
    input wire logic [7:0]  portp_pull_down,
    input wire logic [7:0]  portp_low_drive
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // -----------------------------------------------
    // Pins quiet long enough to cross the synchroniser.
    // -----------------------------------------------
    sequence s_pins_still;
        $stable(portp_pin_in) [*3];
    endsequence
    sequence s_level_setup;
        psel && !penable && !pwrite && paddr == 12'h064;
    endsequence
    a_reset_pulls: assert property ($fell(sys_rst) |=> portm_pull_up == 6'h3f &&
        portp_pull_up == 8'h00 && portp_pull_down == 8'h00) else $error("pulls wrong after reset");
    a_pm_pull_excl: assert property ((portm_pull_up & portm_pull_down) == 6'h00)
        else $error("port M pull up and down together");
    a_pp_pull_excl: assert property ((portp_pull_up & portp_pull_down) == 8'h00)
        else $error("port P pull up and down together");
    a_pm_down_input: assert property ((portm_pull_down & portm_pin_oe) == 6'h00)
        else $error("port M pull-down on an output");
    a_pp_pull_input: assert property (((portp_pull_up | portp_pull_down) & portp_pin_oe) == 8'h00)
        else $error("port P pull on an output");
    a_pp_low_out: assert property ((portp_low_drive & ~portp_pin_oe) == 8'h00)
        else $error("reduced drive on an input");
    a_pm_upper_zero: assert property (psel && penable && !pwrite && paddr inside {12'h050, 12'h054, 12'h058}
        |-> prdata[31:6] == 26'h0) else $error("port M upper bits not zero");
    a_pin_level_read: assert property (s_pins_still ##0 s_level_setup |=> prdata[7:0] == $past(portp_pin_in))
        else $error("pin level read wrong");
    a_ready_now: assert property (pready == (psel && penable))
        else $error("ready not in access phase");
endmodule
bind ppc_port_pad_config_regs ppc_pad_monitor u_mon (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .portm_pin_oe, .portm_pull_up, .portm_pull_down, .portp_pin_in, .portp_pin_oe,
    .portp_pull_up, .portp_pull_down, .portp_low_drive);

// ==== verif/ppc_port_pad_config_regs_tb.sv ====
// Self-checking bench of the port pad block against a register model.
`timescale 1ns/100ps
module ppc_port_pad_config_regs_tb;
    logic [0:0]  clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'h0;
    logic        pready, pslverr;
    logic [5:0]  portm_pin_in = 6'h00, portm_pin_out, portm_pin_oe, portm_pull_up, portm_pull_down;
    logic [7:0]  portp_pin_in = 8'h00, portp_pin_out, portp_pin_oe, portp_pull_up, portp_pull_down;
    logic [7:0]  portp_low_drive;
    int          n_mismatch = 0, cmp_count = 0, seed = 89375;
    logic [7:0]  mdl [int];  // Model registers by byte address.
    logic [11:0] adr [13] = '{12'h040, 12'h048, 12'h050, 12'h054, 12'h058, 12'h060, 12'h064, 12'h068,
                              12'h06c, 12'h070, 12'h074, 12'h07c, 12'h062};
    always #2 clock = ~clock;
    ppc_port_pad_config_regs dut (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .portm_pin_in, .portm_pin_out, .portm_pin_oe, .portm_pull_up,
        .portm_pull_down, .portp_pin_in, .portp_pin_out, .portp_pin_oe, .portp_pull_up, .portp_pull_down,
        .portp_low_drive);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the master waits for pready, and only the watchdog ends a hang.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s,
                       output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pstrb <= {3'h7, s};
        pwdata <= ($random(seed) & 32'hffff_ff00) | {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Data words mux latch and pins by direction; the level word is the pins.
    function automatic logic [31:0] exp_rd(input logic [11:0] a);
        if (!mdl.exists(a)) return 32'h0;
        if (a == 12'h064) return {24'h0, portp_pin_in};
        if (a == 12'h060) return {24'h0, (mdl[a] & mdl[12'h068]) | (portp_pin_in & ~mdl[12'h068])};
        if (a == 12'h040) return {24'h0, (mdl[a] & mdl[12'h048]) | ({2'h0, portm_pin_in} & ~mdl[12'h048])};
        return {24'h0, mdl[a]};
    endfunction
    task automatic pads;
        logic [7:0] dr, dt, pe, po, wm;
        dr = mdl[12'h048]; dt = mdl[12'h040]; pe = mdl[12'h050]; po = mdl[12'h054]; wm = mdl[12'h058];
        chk(portm_pull_up, pe & ~po & (~dr | wm));
        chk(portm_pull_down, pe & po & ~dr);
        chk(portm_pin_oe, dr & ~(wm & dt));
        chk(portm_pin_out & portm_pin_oe, dt & dr & ~wm);
        dr = mdl[12'h068]; dt = mdl[12'h060]; pe = mdl[12'h070]; po = mdl[12'h074];
        chk(portp_pin_oe, dr);
        chk(portp_pin_out & dr, dt & dr);
        chk(portp_pull_up, pe & ~po & ~dr);
        chk(portp_pull_down, pe & po & ~dr);
        chk(portp_low_drive, mdl[12'h06c] & dr);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
    initial begin
        logic [31:0] r; logic e, w, s; logic [11:0] a; logic [7:0] d;
        for (int i = 0; i < 11; i++) mdl[adr[i]] = 8'h00;
        mdl[12'h050] = 8'h3f;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
        pads();
        foreach (adr[i]) begin
            apb(1'b0, adr[i], 8'h00, 1'b1, r, e);
            chk(r, exp_rd(adr[i]));
            chk(e, !mdl.exists(adr[i]));
        end
        $display("reset values test done");
        // Random traffic; a pin change waits three cycles so reads never see stale pins.
        repeat (300) begin
            a = adr[{$random(seed)} % 13]; w = $random(seed); s = $random(seed); d = $random(seed);
            if ({$random(seed)} % 8 == 0) begin
                portm_pin_in <= $random(seed); portp_pin_in <= $random(seed);
                repeat (3) @(posedge clock);
            end
            apb(w, a, d, s, r, e);
            chk(e, !mdl.exists(a));
            if (!w) chk(r, exp_rd(a));
            else if (s && mdl.exists(a) && a != 12'h064) mdl[a] = d & (a < 12'h060 ? 8'h3f : 8'hff);
            repeat (2) @(posedge clock);
            pads();
        end
        $display("random traffic test done");
        results();
    end
endmodule
